// ---- verilog/selective_wake_regs.vh ----
// Register offsets, field positions, reset values and timing for the selective wake bank
`ifndef SELECTIVE_WAKE_REGS_VH
`define SELECTIVE_WAKE_REGS_VH

// ----------------------------------------------------------------
// Register offsets (7-bit register addresses)
// ----------------------------------------------------------------
`define SW_ADDR_PAYLOAD_TWO   7'h31
`define SW_ADDR_PAYLOAD_ONE   7'h32
`define SW_ADDR_PAYLOAD_ZERO  7'h33
`define SW_ADDR_FD_CONFIG     7'h34
`define SW_ADDR_OSC_TRIM      7'h38
`define SW_ADDR_OPTIONS       7'h39
`define SW_ADDR_OSC_CAL_HIGH  7'h3a
`define SW_ADDR_OSC_CAL_LOW   7'h3b

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SW_FD_ERR_OFF_BIT     5
`define SW_FD_FILT_SKIP_BIT   4
`define SW_FD_GLITCH_MSB      3
`define SW_FD_GLITCH_LSB      1
`define SW_FD_ON_BIT          0
`define SW_TRIM_MSB           6
`define SW_OPT_RX_CHOICE_BIT  7
`define SW_OPT_PRESET_MSB     4
`define SW_TRIM_UNLOCK_CODE   2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SW_RST_PAYLOAD        8'h00
`define SW_RST_FD_CONFIG      6'h00
`define SW_RST_OSC_CAL        8'h00
`define SW_RST_RX_CHOICE      1'h0

// ----------------------------------------------------------------
// Dominant glitch filter timing
// ----------------------------------------------------------------
`define SW_GLITCH_STEP_NS     50
`define SW_GLITCH_LONG_NS     700
`define SW_CLK_PERIOD_NS      20

`endif

// ---- verilog/selective_wake_config_regs.v ----
// Selective wake configuration and status register bank with FD tolerant controls
// Functional notes
// - Three payload byte registers, 8-bit read/write, zero after power-on or soft reset.
// - FD configuration bits 7:6 always read zero.
// - Error counter off bit disables counter only while FD tolerant mode is on.
// - Hardware clears error counter off bit when bus silence timeout expires.
// - Filter skip bit routes received signal around the analog input filter.
// - Dominant glitch filter stays active even when the input filter is skipped.
// - Glitch time codes 0-6 give 50-350 ns, code 7 gives 700 ns.
// - FD configuration bit 0 enables FD tolerant mode.
// - Seven-bit trim field writable only while trim unlock equals 11.
// - Receiver choice bit writable only while trim unlock equals 11.
// - Receiver choice 0 picks low-power receiver, 1 picks standard receiver.
// - Receiver choice resets to 0, the low-power receiver.
// - Two oscillator calibration registers are read-only, zero after reset.
// - Restart clears FD config bits 7:6 and keeps the remaining bits.
// - Trim register clears to zero on reset and loads its preset at the first enabled clock after release or on soft reset.
`timescale 1ns/10ps
`include "selective_wake_regs.vh"

module selective_wake_config_regs #(
  parameter [6:0] TRIM_PRESET     = 7'h40,
  parameter       TRIM_RSV_PRESET = 1'b0,
  parameter [4:0] OPT_RSV_PRESET  = 5'h00
) (
  input  wire       i_clk_sys,
  input  wire       i_arst_n,
  input  wire       i_clk_en,
  input  wire       i_soft_rst,
  input  wire       i_restart,
  input  wire       i_wr_en,
  input  wire       i_rd_en,
  input  wire [6:0] i_addr,
  input  wire [7:0] i_wr_data,
  input  wire [1:0] i_trim_unlock,
  input  wire       i_silence_expired,
  input  wire       i_cal_load,
  input  wire [7:0] i_cal_high,
  input  wire [7:0] i_cal_low,
  input  wire       i_rx_raw,
  input  wire       i_rx_filtered,
  output reg  [7:0] o_rd_data,
  output reg        o_rd_valid,
  output reg  [7:0] o_payload_byte_two,
  output reg  [7:0] o_payload_byte_one,
  output reg  [7:0] o_payload_byte_zero,
  output reg        o_fd_tolerant_on,
  output reg        o_error_counter_off,
  output reg  [3:0] o_glitch_cycles,
  output reg        o_rx_to_detector,
  output reg        o_wake_receiver_choice,
  output reg  [6:0] o_osc_trim
);

  // ----------------------------------------------------------------
  // Glitch time conversion
  // ----------------------------------------------------------------
  localparam integer STEP_NS = `SW_GLITCH_STEP_NS;
  localparam integer LONG_NS = `SW_GLITCH_LONG_NS;
  localparam integer PER_NS  = `SW_CLK_PERIOD_NS;

  // Reserved bits that always read zero; nothing stores them, so restart clears them too
  localparam [1:0] FD_RSV_READ  = 2'b00;
  localparam [1:0] OPT_RSV_READ = 2'b00;

  // Glitch code to filter time in ns, then whole cycles rounded up
  function [5:0] glitch_cycles;
    input [2:0] code;
    integer     ns;
    integer     cyc;
    begin
      case (code)
        3'h7:    ns = LONG_NS;
        default: ns = (code + 1) * STEP_NS;
      endcase
      // Round up so the filter is never shorter than the chosen time
      cyc           = (ns + PER_NS - 1) / PER_NS;
      glitch_cycles = cyc[5:0];
    end
  endfunction

  // Address match, shared by the write and read decoders
  function reg_sel;
    input [6:0] addr;
    input [6:0] target;
    begin
      reg_sel = (addr == target);
    end
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Stored fields
  reg  [7:0] payload_two_r;
  reg  [7:0] payload_one_r;
  reg  [7:0] payload_zero_r;
  reg        err_off_r;
  reg        filt_skip_r;
  reg  [2:0] glitch_code_r;
  reg        fd_on_r;
  reg  [6:0] trim_r;
  reg        trim_rsv_r;
  reg        rx_choice_r;
  reg  [4:0] opt_rsv_r;
  reg  [7:0] cal_high_r;
  reg  [7:0] cal_low_r;
  // Preset loaded flag and glitch filter state
  reg        preset_done_r;
  reg  [5:0] glitch_cnt_r;
  reg        rx_held_r;

  // Decode, path and read nets
  wire       unlocked;
  wire       wr_payload_two;
  wire       wr_payload_one;
  wire       wr_payload_zero;
  wire       wr_fd;
  wire       wr_trim;
  wire       wr_opt;
  wire       rx_path;
  wire [5:0] glitch_limit;
  reg  [7:0] rd_nxt;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign unlocked        = (i_trim_unlock == `SW_TRIM_UNLOCK_CODE);
  assign wr_payload_two  = i_wr_en && reg_sel(i_addr, `SW_ADDR_PAYLOAD_TWO);
  assign wr_payload_one  = i_wr_en && reg_sel(i_addr, `SW_ADDR_PAYLOAD_ONE);
  assign wr_payload_zero = i_wr_en && reg_sel(i_addr, `SW_ADDR_PAYLOAD_ZERO);
  assign wr_fd           = i_wr_en && reg_sel(i_addr, `SW_ADDR_FD_CONFIG);
  assign wr_trim         = i_wr_en && reg_sel(i_addr, `SW_ADDR_OSC_TRIM);
  assign wr_opt          = i_wr_en && reg_sel(i_addr, `SW_ADDR_OPTIONS);

  // ----------------------------------------------------------------
  // Receive path into the dominant glitch filter
  // ----------------------------------------------------------------
  // Skip the analog filter when requested
  assign rx_path      = filt_skip_r ? i_rx_raw : i_rx_filtered;
  assign glitch_limit = glitch_cycles(glitch_code_r);

  // ----------------------------------------------------------------
  // Payload bytes: reset to zero, restart leaves them alone
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      payload_two_r  <= `SW_RST_PAYLOAD;
      payload_one_r  <= `SW_RST_PAYLOAD;
      payload_zero_r <= `SW_RST_PAYLOAD;
    end else if (i_clk_en) begin
      if (i_soft_rst) begin
        payload_two_r  <= `SW_RST_PAYLOAD;
        payload_one_r  <= `SW_RST_PAYLOAD;
        payload_zero_r <= `SW_RST_PAYLOAD;
      // Soft reset outranks a write in the same cycle
      end else if (wr_payload_two) begin
        payload_two_r  <= i_wr_data;
      end else if (wr_payload_one) begin
        payload_one_r  <= i_wr_data;
      end else if (wr_payload_zero) begin
        payload_zero_r <= i_wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // FD configuration; bits 7:6 are not stored, restart keeps the rest
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {err_off_r, filt_skip_r, glitch_code_r, fd_on_r} <= `SW_RST_FD_CONFIG;
    end else if (i_clk_en) begin
      if (i_soft_rst) begin
        {err_off_r, filt_skip_r, glitch_code_r, fd_on_r} <= `SW_RST_FD_CONFIG;
      end else begin
        // Plain read/write fields
        if (wr_fd) begin
          filt_skip_r   <= i_wr_data[`SW_FD_FILT_SKIP_BIT];
          glitch_code_r <= i_wr_data[`SW_FD_GLITCH_MSB:`SW_FD_GLITCH_LSB];
          fd_on_r       <= i_wr_data[`SW_FD_ON_BIT];
        end
        // Silence timeout clear wins over a software write
        if (i_silence_expired) begin
          err_off_r <= 1'b0;
        end else if (wr_fd) begin
          err_off_r <= i_wr_data[`SW_FD_ERR_OFF_BIT];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Trim and options; preset loaded after reset release and again on every soft reset
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      trim_r        <= 7'h00;
      trim_rsv_r    <= 1'b0;
      opt_rsv_r     <= 5'h00;
      rx_choice_r   <= `SW_RST_RX_CHOICE;
      preset_done_r <= 1'b0;
    end else if (i_clk_en) begin
      if (!preset_done_r || i_soft_rst) begin
        trim_r        <= TRIM_PRESET;
        trim_rsv_r    <= TRIM_RSV_PRESET;
        opt_rsv_r     <= OPT_RSV_PRESET;
        rx_choice_r   <= `SW_RST_RX_CHOICE;
        preset_done_r <= 1'b1;
      end else begin
        // Reserved bits take any write, locked or not, so a write replaces their presets
        if (wr_trim) begin
          trim_rsv_r <= i_wr_data[7];
          if (unlocked) begin
            trim_r <= i_wr_data[`SW_TRIM_MSB:0];
          end
        end
        // Receiver choice is locked like the trim field
        if (wr_opt) begin
          opt_rsv_r <= i_wr_data[`SW_OPT_PRESET_MSB:0];
          if (unlocked) begin
            rx_choice_r <= i_wr_data[`SW_OPT_RX_CHOICE_BIT];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Calibration status, read-only to software
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cal_high_r <= `SW_RST_OSC_CAL;
      cal_low_r  <= `SW_RST_OSC_CAL;
    end else if (i_clk_en) begin
      if (i_soft_rst) begin
        cal_high_r <= `SW_RST_OSC_CAL;
        cal_low_r  <= `SW_RST_OSC_CAL;
      // Values come from the calibration logic, never from writes
      end else if (i_cal_load) begin
        cal_high_r <= i_cal_high;
        cal_low_r  <= i_cal_low;
      end
    end
  end

  // ----------------------------------------------------------------
  // Dominant glitch filter, always in the path after the skip mux
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      glitch_cnt_r <= 6'h00;
      rx_held_r    <= 1'b1;
    end else if (i_clk_en) begin
      // Count cycles that disagree with the held level; agreement restarts
      if (rx_path == rx_held_r) begin
        glitch_cnt_r <= 6'h00;
      end else if (glitch_cnt_r + 6'h01 >= glitch_limit) begin
        rx_held_r    <= rx_path;
        glitch_cnt_r <= 6'h00;
      end else begin
        glitch_cnt_r <= glitch_cnt_r + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always @* begin
    // Unmapped addresses read zero
    rd_nxt = 8'h00;
    if (reg_sel(i_addr, `SW_ADDR_PAYLOAD_TWO)) begin
      rd_nxt = payload_two_r;
    end else if (reg_sel(i_addr, `SW_ADDR_PAYLOAD_ONE)) begin
      rd_nxt = payload_one_r;
    end else if (reg_sel(i_addr, `SW_ADDR_PAYLOAD_ZERO)) begin
      rd_nxt = payload_zero_r;
    end else if (reg_sel(i_addr, `SW_ADDR_FD_CONFIG)) begin
      rd_nxt = {FD_RSV_READ, err_off_r, filt_skip_r, glitch_code_r, fd_on_r};
    end else if (reg_sel(i_addr, `SW_ADDR_OSC_TRIM)) begin
      rd_nxt = {trim_rsv_r, trim_r};
    end else if (reg_sel(i_addr, `SW_ADDR_OPTIONS)) begin
      rd_nxt = {rx_choice_r, OPT_RSV_READ, opt_rsv_r};
    end else if (reg_sel(i_addr, `SW_ADDR_OSC_CAL_HIGH)) begin
      rd_nxt = cal_high_r;
    end else if (reg_sel(i_addr, `SW_ADDR_OSC_CAL_LOW)) begin
      rd_nxt = cal_low_r;
    end
  end

  // ----------------------------------------------------------------
  // Read port outputs
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data  <= 8'h00;
      o_rd_valid <= 1'b0;
    end else if (i_clk_en) begin
      // Valid pulses once per read; data holds until the next read
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= rd_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Field mirror outputs, one cycle behind storage
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_payload_byte_two     <= 8'h00;
      o_payload_byte_one     <= 8'h00;
      o_payload_byte_zero    <= 8'h00;
      o_fd_tolerant_on       <= 1'b0;
      o_error_counter_off    <= 1'b0;
      o_glitch_cycles        <= 4'h0;
      o_rx_to_detector       <= 1'b1;
      o_wake_receiver_choice <= 1'b0;
      o_osc_trim             <= 7'h00;
    end else if (i_clk_en) begin
      // Payload copies for the frame decoder
      o_payload_byte_two     <= payload_two_r;
      o_payload_byte_one     <= payload_one_r;
      o_payload_byte_zero    <= payload_zero_r;
      // FD tolerant controls; counter off needs FD mode
      o_fd_tolerant_on       <= fd_on_r;
      o_error_counter_off    <= err_off_r && fd_on_r;
      o_glitch_cycles        <= glitch_limit[3:0] > 4'h0 ? glitch_limit[3:0] : 4'h0;
      o_rx_to_detector       <= rx_held_r;
      o_wake_receiver_choice <= rx_choice_r;
      o_osc_trim             <= trim_r;
    end
  end

endmodule

// ---- bench/selective_wake_config_regs_checker.sv ----
// Port-level assertions for the selective wake register bank
`timescale 1ns/10ps
module selective_wake_config_regs_checker (
  input logic       i_clk_sys,
  input logic       i_arst_n,
  input logic       i_clk_en,
  input logic       i_soft_rst,
  input logic       i_restart,
  input logic       i_wr_en,
  input logic       i_rd_en,
  input logic       i_silence_expired,
  input logic [6:0] i_addr,
  input logic [1:0] i_trim_unlock,
  input logic [7:0] o_rd_data,
  input logic [7:0] o_payload_byte_two,
  input logic       o_rd_valid,
  input logic       o_fd_tolerant_on,
  input logic       o_error_counter_off,
  input logic       o_wake_receiver_choice,
  input logic [6:0] o_osc_trim
);
  // ----
  // Relations between strobes and registered outputs
  // ----
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  AST_RD_VALID: assert property (i_rd_en && i_clk_en |=> o_rd_valid)
    else $error("read gave no valid pulse");
  AST_RD_HOLD: assert property (!(i_rd_en && i_clk_en) |=> $stable(o_rd_data))
    else $error("read data moved without a read");
  AST_FD_RSV: assert property (i_rd_en && i_clk_en && i_addr == 7'h34 |=> o_rd_data[7:6] == 2'h0)
    else $error("fd config top bits not zero");
  AST_ERR_GATE: assert property (o_error_counter_off |-> o_fd_tolerant_on)
    else $error("counter off without fd mode");
  AST_SILENCE: assert property (i_silence_expired && i_clk_en ##1 i_clk_en |=> !o_error_counter_off)
    else $error("silence did not clear counter off");
  AST_TRIM_LOCK: assert property (i_wr_en && i_clk_en && !i_soft_rst && i_addr == 7'h38 &&
    i_trim_unlock != 2'h3 |-> ##2 $stable(o_osc_trim)) else $error("locked trim write took effect");
  AST_CHOICE_LOCK: assert property (i_wr_en && i_clk_en && !i_soft_rst && i_addr == 7'h39 &&
    i_trim_unlock != 2'h3 |-> ##2 $stable(o_wake_receiver_choice)) else $error("locked choice write took effect");
  AST_SOFT_RST: assert property (i_soft_rst && i_clk_en ##1 i_clk_en |=>
    o_payload_byte_two == 8'h00 && !o_fd_tolerant_on && !o_wake_receiver_choice) else $error("soft reset missed");
  AST_RESTART: assert property (i_restart && !i_wr_en && !i_soft_rst |->
    ##2 $stable(o_payload_byte_two) && $stable(o_fd_tolerant_on)) else $error("restart changed stored fields");
endmodule

bind selective_wake_config_regs selective_wake_config_regs_checker selective_wake_config_regs_checker_inst (
  .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en), .i_soft_rst(i_soft_rst),
  .i_restart(i_restart), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_silence_expired(i_silence_expired),
  .i_addr(i_addr), .i_trim_unlock(i_trim_unlock), .o_rd_data(o_rd_data), .o_payload_byte_two(o_payload_byte_two),
  .o_rd_valid(o_rd_valid), .o_fd_tolerant_on(o_fd_tolerant_on), .o_error_counter_off(o_error_counter_off),
  .o_wake_receiver_choice(o_wake_receiver_choice), .o_osc_trim(o_osc_trim));

// ---- bench/selective_wake_config_regs_tb_top.sv ----
// Self-checking bench for the selective wake register bank
`timescale 1ns/10ps
`define CHK(g, e) begin checked = checked + 1; if ((g) !== (e)) begin error_cnt = error_cnt + 1; \
  $display("Error at %0t: got %h exp %h", $time, (g), (e)); end end
module selective_wake_config_regs_tb_top;
  reg        i_clk_sys, i_arst_n, i_clk_en, i_soft_rst, i_restart, i_wr_en, i_rd_en;
  reg        i_silence_expired, i_cal_load, i_rx_raw, i_rx_filtered;
  reg  [6:0] i_addr;
  reg  [7:0] i_wr_data, i_cal_high, i_cal_low;
  reg  [1:0] i_trim_unlock;
  reg  [3:0] gexp;
  wire [7:0] o_rd_data, o_payload_byte_two, o_payload_byte_one, o_payload_byte_zero;
  wire       o_rd_valid, o_fd_tolerant_on, o_error_counter_off, o_rx_to_detector, o_wake_receiver_choice;
  wire [3:0] o_glitch_cycles;
  wire [6:0] o_osc_trim;
  integer    error_cnt, checked, k;

  // Presets differ from defaults so a constant reset shows up
  selective_wake_config_regs #(.TRIM_PRESET(7'h2b), .TRIM_RSV_PRESET(1'b1), .OPT_RSV_PRESET(5'h16))
    selective_wake_config_regs_inst (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en), .i_soft_rst(i_soft_rst),
    .i_restart(i_restart), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_trim_unlock(i_trim_unlock), .i_silence_expired(i_silence_expired), .i_cal_load(i_cal_load),
    .i_cal_high(i_cal_high), .i_cal_low(i_cal_low), .i_rx_raw(i_rx_raw), .i_rx_filtered(i_rx_filtered),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_payload_byte_two(o_payload_byte_two),
    .o_payload_byte_one(o_payload_byte_one), .o_payload_byte_zero(o_payload_byte_zero),
    .o_fd_tolerant_on(o_fd_tolerant_on), .o_error_counter_off(o_error_counter_off),
    .o_glitch_cycles(o_glitch_cycles), .o_rx_to_detector(o_rx_to_detector),
    .o_wake_receiver_choice(o_wake_receiver_choice), .o_osc_trim(o_osc_trim));

  // ----
  // Clock and bus tasks
  // ----
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  task idle(input integer n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  task pulse_restart;
    begin
      i_restart = 1'b1;
      idle(1);
      i_restart = 1'b0;
    end
  endtask
  task wr(input [6:0] a, input [7:0] d);
    begin
      i_addr = a;
      i_wr_data = d;
      i_wr_en = 1'b1;
      idle(1);
      // Strobe low for a cycle so back to back calls never retoggle it
      i_wr_en = 1'b0;
      idle(1);
    end
  endtask
  // Read, wait for the valid pulse, compare
  task rdc(input [6:0] a, input [7:0] e);
    integer n;
    begin
      i_addr = a;
      i_rd_en = 1'b1;
      idle(1);
      i_rd_en = 1'b0;
      n = 0;
      while (o_rd_valid !== 1'b1 && n < 4) begin
        idle(1);
        n = n + 1;
      end
      if (n == 4) begin
        error_cnt = error_cnt + 1;
        complete_run;
      end
      `CHK(o_rd_data, e)
      idle(1);
      `CHK(o_rd_valid, 1'b0)
    end
  endtask
  task complete_run;
    begin
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // ----
  // Scenarios
  // ----
  task t_reset;
    begin
      rdc(7'h31, 8'h00);
      rdc(7'h33, 8'h00);
      rdc(7'h34, 8'h00);
      rdc(7'h38, 8'hab);
      rdc(7'h39, 8'h16);
      rdc(7'h3b, 8'h00);
      rdc(7'h35, 8'h00);
      $display("t_reset end");
    end
  endtask
  task t_payload;
    begin
      wr(7'h31, 8'ha5);
      wr(7'h32, 8'h5a);
      wr(7'h33, 8'hff);
      idle(2);
      `CHK(o_payload_byte_two, 8'ha5)
      `CHK(o_payload_byte_one, 8'h5a)
      `CHK(o_payload_byte_zero, 8'hff)
      i_clk_en = 1'b0;
      wr(7'h31, 8'h00);
      i_clk_en = 1'b1;
      pulse_restart;
      rdc(7'h31, 8'ha5);
      rdc(7'h33, 8'hff);
      i_soft_rst = 1'b1;
      idle(1);
      i_soft_rst = 1'b0;
      rdc(7'h32, 8'h00);
      $display("t_payload end");
    end
  endtask
  task t_fd;
    begin
      wr(7'h34, 8'hff);
      rdc(7'h34, 8'h3f);
      `CHK(o_error_counter_off, 1'b1)
      `CHK(o_fd_tolerant_on, 1'b1)
      wr(7'h34, 8'h20);
      idle(2);
      `CHK(o_error_counter_off, 1'b0)
      `CHK(o_fd_tolerant_on, 1'b0)
      wr(7'h34, 8'h21);
      i_silence_expired = 1'b1;
      idle(1);
      i_silence_expired = 1'b0;
      rdc(7'h34, 8'h01);
      pulse_restart;
      rdc(7'h34, 8'h01);
      for (k = 0; k < 8; k = k + 1) begin
        wr(7'h34, {4'h0, k[2:0], 1'b0});
        idle(2);
        gexp = (((k == 7) ? 700 : 50 * (k + 1)) + 19) / 20;
        `CHK(o_glitch_cycles, gexp)
      end
      $display("t_fd end");
    end
  endtask
  task t_filter;
    begin
      wr(7'h34, 8'h00);
      idle(8);
      i_rx_filtered = 1'b0;
      idle(8);
      `CHK(o_rx_to_detector, 1'b0)
      wr(7'h34, 8'h10);
      idle(8);
      `CHK(o_rx_to_detector, 1'b1)
      i_rx_raw = 1'b0;
      idle(1);
      i_rx_raw = 1'b1;
      idle(8);
      `CHK(o_rx_to_detector, 1'b1)
      i_rx_raw = 1'b0;
      idle(8);
      `CHK(o_rx_to_detector, 1'b0)
      $display("t_filter end");
    end
  endtask
  task t_trim;
    begin
      wr(7'h38, 8'h95);
      rdc(7'h38, 8'hab);
      i_trim_unlock = 2'h3;
      wr(7'h38, 8'h95);
      rdc(7'h38, 8'h95);
      `CHK(o_osc_trim, 7'h15)
      i_trim_unlock = 2'h1;
      wr(7'h39, 8'h96);
      rdc(7'h39, 8'h16);
      i_trim_unlock = 2'h3;
      wr(7'h39, 8'h96);
      rdc(7'h39, 8'h96);
      `CHK(o_wake_receiver_choice, 1'b1)
      wr(7'h3a, 8'hff);
      rdc(7'h3a, 8'h00);
      i_cal_high = 8'h9c;
      i_cal_low = 8'h3e;
      i_cal_load = 1'b1;
      idle(1);
      i_cal_load = 1'b0;
      rdc(7'h3a, 8'h9c);
      rdc(7'h3b, 8'h3e);
      i_soft_rst = 1'b1;
      idle(1);
      i_soft_rst = 1'b0;
      rdc(7'h39, 8'h16);
      rdc(7'h38, 8'hab);
      `CHK(o_wake_receiver_choice, 1'b0)
      $display("t_trim end");
    end
  endtask

  // Reset, then run every scenario
  initial begin
    error_cnt = 0;
    checked = 0;
    {i_arst_n, i_soft_rst, i_restart, i_wr_en, i_rd_en, i_silence_expired, i_cal_load} = 7'h00;
    {i_clk_en, i_rx_raw, i_rx_filtered} = 3'h7;
    {i_addr, i_wr_data, i_cal_high, i_cal_low, i_trim_unlock} = 33'h0;
    idle(8);
    i_arst_n = 1'b1;
    idle(2);
    t_reset;
    t_payload;
    t_fd;
    t_filter;
    t_trim;
    complete_run;
  end
endmodule
